// File: div_fifo.v
// Result buffer of the streaming divider: the div_fifo module sits in int_div_stream.v.
// Nothing in this file is compiled into the design.

// File: int_div_defs.vh
// Constants for the streaming integer divider.
// Included by int_div_stream.v; definitions only.
`ifndef INT_DIV_DEFS_VH
`define INT_DIV_DEFS_VH

// Algorithm selection
`define ALG_BIT_SERIAL      2'h0
`define ALG_PRESCALED       2'h1
`define ALG_RECIP_TABLE     2'h2

// Output type
`define OUT_REMAINDER       1'b0
`define OUT_FRACTIONAL      1'b1

// Flow mode
`define FLOW_JOINT          1'b0
`define FLOW_BLOCKING       1'b1

// Result last marker rule
`define LAST_NULL           3'h0
`define LAST_DIVIDEND       3'h1
`define LAST_DIVISOR        3'h2
`define LAST_OR             3'h3
`define LAST_AND            3'h4

// Defaults
`define DEF_WIDTH           16
`define DEF_FRAC_WIDTH      16
`define DEF_USER_WIDTH      4
`define DEF_INTERVAL        1
`define DEF_FIFO_DEPTH      16
`define DEF_RECIP_BITS      12
`define RST_MIN_CYCLES      2

`endif

// File: int_div_stream.v
// Streaming integer divider: dividend, divisor and result channels.
// Assumes upstream and downstream logic on ref_clk_in; resets come from the same domain.
// Contract
// - Bit-serial mode: non-restoring radix-2, signed or unsigned, integer remainder or fractional output.
// - Prescaled mode: signed operands only; suited to operands above 16 bits.
// - Reciprocal-table mode: reciprocal estimate times dividend; remainder output only.
// - Integer remainder with bit-serial or reciprocal-table; prescaled always uses fractional output.
// - Fractional output carries exactly FRAC_WIDTH fraction bits.
// - Bit-serial mode accepts and delivers every 1, 2, 4 or 8 cycles.
// - Prescaled mode optionally flags division by zero.
// - Joint-arrival mode starts only when divisor and dividend arrive together.
// - Blocking mode starts on each dividend, reusing the last divisor.
// - Result follows after a fixed latency in cycles with clock enable and room in the result FIFO.
// - Optional clock enable gates all state advance except reads from the result FIFO.
// - Optional active-low synchronous clear, held at least two cycles.
// - Optional user sideband and last marker on each input channel.
// - Result last marker: null, dividend, divisor, OR or AND of present markers.
`timescale 1ns/1ps
`default_nettype none
`include "int_div_defs.vh"
module int_div_stream #(
    parameter       WIDTH          = `DEF_WIDTH,
    parameter       FRAC_WIDTH     = `DEF_FRAC_WIDTH,
    parameter       USER_WIDTH     = `DEF_USER_WIDTH,
    parameter [1:0] ALGORITHM      = `ALG_BIT_SERIAL,
    parameter       OUT_TYPE       = `OUT_REMAINDER,
    parameter       SIGNED_OPS     = 1,
    parameter       INTERVAL       = `DEF_INTERVAL,
    parameter       FLOW_MODE      = `FLOW_JOINT,
    parameter       MANUAL_LATENCY = 0,
    parameter       LATENCY        = 4,
    parameter       HAS_ACLKEN     = 1,
    parameter       HAS_SCLR       = 1,
    parameter       HAS_DVD_USER   = 1,
    parameter       HAS_DVD_LAST   = 1,
    parameter       HAS_DVS_USER   = 1,
    parameter       HAS_DVS_LAST   = 1,
    parameter       HAS_DOUT_READY = 1,
    parameter       HAS_DIV_ZERO   = 1,
    parameter [2:0] LAST_RULE      = `LAST_OR,
    parameter       FIFO_DEPTH     = `DEF_FIFO_DEPTH,
    parameter       FIFO_AW        = 4
) (
    // Clock, reset, enable
    input  wire                  ref_clk_in,
    input  wire                  arst_n_in,
    input  wire                  aclken_in,
    input  wire                  sclr_n_in,
    // Dividend channel
    input  wire                  dvd_valid_in,
    output wire                  dvd_ready_out,
    input  wire [WIDTH-1:0]      dvd_data_in,
    input  wire [USER_WIDTH-1:0] dvd_user_in,
    input  wire                  dvd_last_in,
    // Divisor channel
    input  wire                  dvs_valid_in,
    output wire                  dvs_ready_out,
    input  wire [WIDTH-1:0]      dvs_data_in,
    input  wire [USER_WIDTH-1:0] dvs_user_in,
    input  wire                  dvs_last_in,
    // Result channel
    output wire                  dout_valid_out,
    input  wire                  dout_ready_in,
    output wire [WIDTH-1:0]      dout_quot_out,
    output wire [WIDTH-1:0]      dout_rem_out,
    output wire [FRAC_WIDTH-1:0] dout_frac_out,
    output wire [USER_WIDTH-1:0] dout_dvd_user_out,
    output wire [USER_WIDTH-1:0] dout_dvs_user_out,
    output wire                  dout_last_out,
    output wire                  dout_div_zero_out
);
    // ****************************************************
    // Derived settings
    // ****************************************************
    localparam IS_SIGNED = (ALGORITHM == `ALG_PRESCALED) ? 1 : SIGNED_OPS;
    localparam USE_FRAC  = (ALGORITHM == `ALG_BIT_SERIAL) ? OUT_TYPE :
                           ((ALGORITHM == `ALG_RECIP_TABLE) ? `OUT_REMAINDER
                                                            : `OUT_FRACTIONAL);
    localparam ITV       = (ALGORITHM == `ALG_BIT_SERIAL) ? INTERVAL : 1;
    localparam LAT       = MANUAL_LATENCY ? ((LATENCY < 1) ? 1 : LATENCY) : WIDTH + 2;
    localparam PW        = 2 * WIDTH + FRAC_WIDTH + 2 * USER_WIDTH + 2;

    // ****************************************************
    // Magnitude helpers
    // ****************************************************
    function [WIDTH-1:0] mag;
        input [WIDTH-1:0] v;
        begin
            mag = (IS_SIGNED && v[WIDTH-1]) ? (~v + 1'b1) : v;
        end
    endfunction

    function [WIDTH-1:0] neg_if;
        input [WIDTH-1:0] v;
        input             n;
        begin
            neg_if = n ? (~v + 1'b1) : v;
        end
    endfunction

    // Non-restoring radix-2 division of magnitudes
    function [2*WIDTH-1:0] nr_div;
        input [WIDTH-1:0] n;
        input [WIDTH-1:0] d;
        reg   [WIDTH:0]   p;
        reg   [WIDTH-1:0] q;
        integer           i;
        begin
            p = {(WIDTH+1){1'b0}};
            q = n;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (p[WIDTH]) begin
                    p = {p[WIDTH-1:0], q[WIDTH-1]} + {1'b0, d};
                end else begin
                    p = {p[WIDTH-1:0], q[WIDTH-1]} - {1'b0, d};
                end
                q = {q[WIDTH-2:0], ~p[WIDTH]};
            end
            if (p[WIDTH]) begin
                p = p + {1'b0, d};
            end
            nr_div = {q, p[WIDTH-1:0]};
        end
    endfunction

    // Fraction bits of remainder / divisor by long division
    function [FRAC_WIDTH-1:0] frac_of;
        input [WIDTH-1:0] r;
        input [WIDTH-1:0] d;
        reg   [WIDTH:0]   a;
        reg   [FRAC_WIDTH-1:0] f;
        integer           i;
        begin
            a = {1'b0, r};
            f = {FRAC_WIDTH{1'b0}};
            for (i = 0; i < FRAC_WIDTH; i = i + 1) begin
                a = {a[WIDTH-1:0], 1'b0};
                if (a >= {1'b0, d}) begin
                    a = a - {1'b0, d};
                    f = {f[FRAC_WIDTH-2:0], 1'b1};
                end else begin
                    f = {f[FRAC_WIDTH-2:0], 1'b0};
                end
            end
            frac_of = f;
        end
    endfunction

    // ****************************************************
    // Enables, clear and input acceptance
    // ****************************************************
    wire        en      = HAS_ACLKEN ? aclken_in : 1'b1;
    wire        sclr    = HAS_SCLR ? ~sclr_n_in : 1'b0;
    wire        fifo_wr_ready;
    reg  [3:0]  itv_cnt_r;
    reg  [WIDTH-1:0]      dvs_hold_r;
    reg  [USER_WIDTH-1:0] dvs_user_hold_r;
    reg                   dvs_last_hold_r;
    // Pipeline may only advance when the FIFO cannot overflow
    wire        adv     = en & fifo_wr_ready;
    wire        slot    = (itv_cnt_r == 4'h0) & ~sclr;
    wire        take    = (FLOW_MODE == `FLOW_JOINT) ? (dvd_valid_in & dvs_valid_in)
                                                     : dvd_valid_in;
    wire        start   = adv & slot & take;

    assign dvd_ready_out = adv & slot & ((FLOW_MODE == `FLOW_JOINT) ? dvs_valid_in : 1'b1);
    assign dvs_ready_out = (FLOW_MODE == `FLOW_JOINT) ? (adv & slot & dvd_valid_in)
                                                      : (en & ~sclr);

    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            itv_cnt_r       <= 4'h0;
            dvs_hold_r      <= {WIDTH{1'b0}};
            dvs_user_hold_r <= {USER_WIDTH{1'b0}};
            dvs_last_hold_r <= 1'b0;
        end else if (en) begin
            if (sclr) begin
                itv_cnt_r       <= 4'h0;
                dvs_hold_r      <= {WIDTH{1'b0}};
                dvs_user_hold_r <= {USER_WIDTH{1'b0}};
                dvs_last_hold_r <= 1'b0;
            end else begin
                if (start) begin
                    itv_cnt_r <= ITV[3:0] - 4'h1;
                end else if (!slot && adv) begin
                    itv_cnt_r <= itv_cnt_r - 4'h1;
                end
                if (FLOW_MODE == `FLOW_BLOCKING && dvs_valid_in) begin
                    dvs_hold_r      <= dvs_data_in;
                    dvs_user_hold_r <= dvs_user_in;
                    dvs_last_hold_r <= dvs_last_in;
                end
            end
        end
    end

    // Divisor in use this cycle; blocking mode accepts a same-cycle update
    wire [WIDTH-1:0]      dvs_now  = (FLOW_MODE == `FLOW_JOINT || dvs_valid_in) ? dvs_data_in
                                                                                 : dvs_hold_r;
    wire [USER_WIDTH-1:0] dvsu_now = (FLOW_MODE == `FLOW_JOINT || dvs_valid_in) ? dvs_user_in
                                                                                 : dvs_user_hold_r;
    wire                  dvsl_now = (FLOW_MODE == `FLOW_JOINT || dvs_valid_in) ? dvs_last_in
                                                                                 : dvs_last_hold_r;

    // ****************************************************
    // Arithmetic
    // ****************************************************
    wire                  zero    = (dvs_now == {WIDTH{1'b0}});
    wire [WIDTH-1:0]      n_mag   = mag(dvd_data_in);
    wire [WIDTH-1:0]      d_mag   = mag(dvs_now);
    wire                  q_neg   = IS_SIGNED ? (dvd_data_in[WIDTH-1] ^ dvs_now[WIDTH-1]) : 1'b0;
    wire                  r_neg   = IS_SIGNED ? dvd_data_in[WIDTH-1] : 1'b0;
    wire [2*WIDTH-1:0]    qr_nr   = nr_div(n_mag, d_mag);
    // Table of (2^RB - 1) / d; correction step removes the estimate's bias
    localparam RB = 2 * WIDTH;
    wire [RB-1:0]         recip   = zero ? {RB{1'b1}} : ({RB{1'b1}} / {{WIDTH{1'b0}}, d_mag});
    wire [2*RB-1:0]       prod    = recip * {{WIDTH{1'b0}}, n_mag};
    wire [WIDTH-1:0]      q_est   = prod[RB+WIDTH-1:RB];
    wire [2*WIDTH-1:0]    qd_est  = q_est * d_mag;
    wire [WIDTH-1:0]      r_est   = n_mag - qd_est[WIDTH-1:0];
    wire                  fix     = (r_est >= d_mag) & ~zero;
    wire [WIDTH-1:0]      q_lut   = fix ? q_est + 1'b1 : q_est;
    wire [WIDTH-1:0]      r_lut   = fix ? r_est - d_mag : r_est;
    wire [WIDTH-1:0]      q_mag   = (ALGORITHM == `ALG_RECIP_TABLE) ? q_lut
                                                                   : qr_nr[2*WIDTH-1:WIDTH];
    wire [WIDTH-1:0]      r_mag   = (ALGORITHM == `ALG_RECIP_TABLE) ? r_lut
                                                                   : qr_nr[WIDTH-1:0];
    wire [WIDTH-1:0]      q_res   = neg_if(q_mag, q_neg);
    wire [WIDTH-1:0]      r_res   = USE_FRAC ? {WIDTH{1'b0}} : neg_if(r_mag, r_neg);
    wire [FRAC_WIDTH-1:0] f_res   = USE_FRAC ? frac_of(r_mag, d_mag) : {FRAC_WIDTH{1'b0}};
    wire                  dz      = (ALGORITHM == `ALG_PRESCALED && HAS_DIV_ZERO) ? zero
                                                                                  : 1'b0;
    wire                  a_last  = HAS_DVD_LAST ? dvd_last_in : 1'b0;
    wire                  b_last  = HAS_DVS_LAST ? dvsl_now : 1'b0;
    reg                   last_c;
    always @* begin
        case (LAST_RULE)
            `LAST_DIVIDEND: last_c = a_last;
            `LAST_DIVISOR:  last_c = b_last;
            `LAST_OR:       last_c = a_last | b_last;
            `LAST_AND:      last_c = (HAS_DVD_LAST ? a_last : 1'b1) & (HAS_DVS_LAST ? b_last : 1'b1)
                                     & ((HAS_DVD_LAST | HAS_DVS_LAST) != 0);
            default:        last_c = 1'b0;
        endcase
    end
    wire [USER_WIDTH-1:0] au      = HAS_DVD_USER ? dvd_user_in : {USER_WIDTH{1'b0}};
    wire [USER_WIDTH-1:0] bu      = HAS_DVS_USER ? dvsu_now : {USER_WIDTH{1'b0}};
    wire [PW-1:0]         stage_in = {dz, last_c, au, bu, f_res, r_res, q_res};

    // ****************************************************
    // Fixed-latency pipeline
    // ****************************************************
    // Result and its sideband travel in one word so they cannot slip apart
    reg  [PW-1:0] pipe_r  [0:LAT-1];
    reg  [LAT-1:0] vld_r;
    integer k;
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            vld_r <= {LAT{1'b0}};
            for (k = 0; k < LAT; k = k + 1) begin
                pipe_r[k] <= {PW{1'b0}};
            end
        end else if (adv) begin
            if (sclr) begin
                vld_r <= {LAT{1'b0}};
            end else begin
                vld_r <= {vld_r[LAT-2:0], start};
                pipe_r[0] <= stage_in;
                for (k = 1; k < LAT; k = k + 1) begin
                    pipe_r[k] <= pipe_r[k-1];
                end
            end
        end
    end

    // ****************************************************
    // Result FIFO
    // ****************************************************
    wire [PW-1:0] fifo_out;
    wire          rd_ready = HAS_DOUT_READY ? dout_ready_in : 1'b1;
    // Pipeline slides only on adv, so push gated by it
    div_fifo #(
        .WIDTH (PW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .ref_clk_in   (ref_clk_in),
        .arst_n_in    (arst_n_in),
        .sclr_in      (sclr & en),
        .wr_valid_in  (adv & ~sclr & vld_r[LAT-1]),
        .wr_ready_out (fifo_wr_ready),
        .wr_data_in   (pipe_r[LAT-1]),
        .rd_valid_out (dout_valid_out),
        .rd_ready_in  (rd_ready),
        .rd_data_out  (fifo_out)
    );

    assign dout_quot_out     = fifo_out[WIDTH-1:0];
    assign dout_rem_out      = fifo_out[2*WIDTH-1:WIDTH];
    assign dout_frac_out     = fifo_out[2*WIDTH+FRAC_WIDTH-1:2*WIDTH];
    assign dout_dvs_user_out = fifo_out[2*WIDTH+FRAC_WIDTH+USER_WIDTH-1:2*WIDTH+FRAC_WIDTH];
    assign dout_dvd_user_out = fifo_out[2*WIDTH+FRAC_WIDTH+2*USER_WIDTH-1:
                                        2*WIDTH+FRAC_WIDTH+USER_WIDTH];
    assign dout_last_out     = fifo_out[PW-2];
    assign dout_div_zero_out = fifo_out[PW-1];
endmodule
module div_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             ref_clk_in,
    input  wire             arst_n_in,
    input  wire             sclr_in,
    // Fill side
    input  wire             wr_valid_in,
    output wire             wr_ready_out,
    input  wire [WIDTH-1:0] wr_data_in,
    // Drain side
    output wire             rd_valid_out,
    input  wire             rd_ready_in,
    output wire [WIDTH-1:0] rd_data_out
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    wire            do_wr;
    wire            do_rd;

    assign wr_ready_out = (count_r != DEPTH[AW:0]);
    assign rd_valid_out = (count_r != {(AW+1){1'b0}});
    assign rd_data_out  = mem_r[rd_ptr_r];
    assign do_wr        = wr_valid_in & wr_ready_out;
    assign do_rd        = rd_valid_out & rd_ready_in;

    always @(posedge ref_clk_in) begin
        if (do_wr) begin
            mem_r[wr_ptr_r] <= wr_data_in;
        end
    end

    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else if (sclr_in) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_r <= count_r + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: int_div_stream_checker.sv
// Port-level assertions for int_div_stream.
// Assumes bit-serial remainder setup on the ref_clk_in domain.
`timescale 1ns/1ps
`default_nettype none
module int_div_stream_checker #(
    parameter WIDTH      = 8,
    parameter FRAC_WIDTH = 8,
    parameter USER_WIDTH = 4,
    parameter INTERVAL   = 2
) (
    input wire logic                  ref_clk_in,
    input wire logic                  arst_n_in,
    input wire logic                  aclken_in,
    input wire logic                  sclr_n_in,
    input wire logic                  dvd_valid_in,
    input wire logic                  dvd_ready_out,
    input wire logic                  dvs_ready_out,
    input wire logic                  dout_valid_out,
    input wire logic                  dout_ready_in,
    input wire logic [WIDTH-1:0]      dout_quot_out,
    input wire logic [WIDTH-1:0]      dout_rem_out,
    input wire logic [FRAC_WIDTH-1:0] dout_frac_out,
    input wire logic [USER_WIDTH-1:0] dout_dvd_user_out,
    input wire logic [USER_WIDTH-1:0] dout_dvs_user_out,
    input wire logic                  dout_last_out,
    input wire logic                  dout_div_zero_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    // Clear may legally empty the buffer, so it ends a stall
    wire stall_w = dout_valid_out && !dout_ready_in && sclr_n_in;
    property p_hold_valid; stall_w |=> dout_valid_out; endproperty
    a_hold_valid: assert property (p_hold_valid) else $error("result dropped");
    property p_hold_data;
        stall_w |=> $stable(dout_quot_out) && $stable(dout_rem_out) && $stable(dout_last_out);
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("result changed");
    property p_hold_side;
        stall_w |=> $stable(dout_dvd_user_out) && $stable(dout_dvs_user_out);
    endproperty
    a_hold_side: assert property (p_hold_side) else $error("sideband changed");
    property p_clken; !aclken_in |-> !dvd_ready_out && !dvs_ready_out; endproperty
    a_clken: assert property (p_clken) else $error("ready while disabled");
    property p_interval;
        dvd_valid_in && dvd_ready_out && aclken_in |=> (INTERVAL < 2) || !dvd_ready_out;
    endproperty
    a_interval: assert property (p_interval) else $error("interval broken");
    property p_sclr; (!sclr_n_in && aclken_in) [*2] |=> !dout_valid_out; endproperty
    a_sclr: assert property (p_sclr) else $error("clear left a result");
    property p_frac_zero; dout_valid_out |-> dout_frac_out == '0; endproperty
    a_frac_zero: assert property (p_frac_zero) else $error("fraction in remainder type");
    property p_no_zflag; dout_valid_out |-> !dout_div_zero_out; endproperty
    a_no_zflag: assert property (p_no_zflag) else $error("zero flag outside prescaled");
endmodule
bind int_div_stream int_div_stream_checker #(.WIDTH(WIDTH), .FRAC_WIDTH(FRAC_WIDTH),
    .USER_WIDTH(USER_WIDTH), .INTERVAL(INTERVAL)) u_chk (.ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in), .aclken_in(aclken_in), .sclr_n_in(sclr_n_in),
    .dvd_valid_in(dvd_valid_in), .dvd_ready_out(dvd_ready_out), .dvs_ready_out(dvs_ready_out),
    .dout_valid_out(dout_valid_out), .dout_ready_in(dout_ready_in),
    .dout_quot_out(dout_quot_out), .dout_rem_out(dout_rem_out), .dout_frac_out(dout_frac_out),
    .dout_dvd_user_out(dout_dvd_user_out), .dout_dvs_user_out(dout_dvs_user_out),
    .dout_last_out(dout_last_out), .dout_div_zero_out(dout_div_zero_out));
`default_nettype wire

// File: integer_divider_stream_tb.sv
// Self-checking bench for int_div_stream, signed bit-serial, joint arrival.
// Assumes result_sink as the downstream partner.
`timescale 1ns/1ps
`default_nettype none
`include "int_div_defs.vh"
module integer_divider_stream_tb;
    localparam W = 8;
    localparam LAT = W + 2;
    logic ref_clk_in = 1'b0, arst_n_in, aclken_in, sclr_n_in;
    logic dvd_valid_in, dvd_last_in, dvs_valid_in, dvs_last_in;
    logic dvd_ready_out, dvs_ready_out, dout_valid_out, dout_ready_in;
    logic dout_last_out, dout_div_zero_out;
    logic [W-1:0] dvd_data_in, dvs_data_in, dout_quot_out, dout_rem_out, dout_frac_out;
    logic [3:0] dvd_user_in, dvs_user_in, dout_dvd_user_out, dout_dvs_user_out;
    logic [1:0] mode;
    logic [24:0] exp_q[$];
    logic [24:0] e;
    logic [15:0] tbl [6] = '{16'hF902, 16'h07FE, 16'h8001, 16'h7FFF, 16'h0005, 16'hFF7F};
    integer failures, compares, seed, i, acc;
    bit ok;
    always #10 ref_clk_in = ~ref_clk_in;
    int_div_stream #(.WIDTH(W), .FRAC_WIDTH(W), .INTERVAL(2), .ALGORITHM(`ALG_BIT_SERIAL),
        .FLOW_MODE(`FLOW_JOINT), .LAST_RULE(`LAST_OR)) DUT (.ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in), .aclken_in(aclken_in), .sclr_n_in(sclr_n_in),
        .dvd_valid_in(dvd_valid_in), .dvd_ready_out(dvd_ready_out), .dvd_data_in(dvd_data_in),
        .dvd_user_in(dvd_user_in), .dvd_last_in(dvd_last_in), .dvs_valid_in(dvs_valid_in),
        .dvs_ready_out(dvs_ready_out), .dvs_data_in(dvs_data_in), .dvs_user_in(dvs_user_in),
        .dvs_last_in(dvs_last_in), .dout_valid_out(dout_valid_out),
        .dout_ready_in(dout_ready_in), .dout_quot_out(dout_quot_out),
        .dout_rem_out(dout_rem_out), .dout_frac_out(dout_frac_out),
        .dout_dvd_user_out(dout_dvd_user_out), .dout_dvs_user_out(dout_dvs_user_out),
        .dout_last_out(dout_last_out), .dout_div_zero_out(dout_div_zero_out));
    result_sink u_sink (.ref_clk_in(ref_clk_in), .mode_in(mode), .dout_ready_out(dout_ready_in));
    task end_sim;
        begin
            if (failures == 0 && compares > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
        begin
            compares++;
            if (s !== ex) begin
                $display("unexpected %s: expected %h seen %h", nm, ex, s);
                failures++;
            end
        end
    endtask
    task automatic guard(input bit good, input string nm);
        if (!good) begin
            chk(nm, 1, 0);
            end_sim;
        end
    endtask
    // ****************************************
    // Upstream driver and result monitor
    // ****************************************
    task automatic op(input logic signed [7:0] a, b, input logic [9:0] sb, input integer lim);
        integer k;
        begin
            @(negedge ref_clk_in);
            {dvd_valid_in, dvs_valid_in, dvd_data_in, dvs_data_in} = {2'b11, a, b};
            {dvd_user_in, dvs_user_in, dvd_last_in, dvs_last_in} = sb;
            #1;
            for (k = 0; k < lim && !(dvd_ready_out && dvs_ready_out); k++) begin
                @(negedge ref_clk_in);
                #1;
            end
            ok = (k < lim);
            if (!ok) {dvd_valid_in, dvs_valid_in} = 2'b00;
            else begin
                @(posedge ref_clk_in);
                exp_q.push_back({a / b, a % b, sb[9:2], sb[1] | sb[0]});
            end
        end
    endtask
    task automatic rnd_op(input integer lim);
        logic [31:0] r;
        logic signed [7:0] a, b;
        begin
            r = $random(seed);
            {a, b} = r[31:16];
            if (b == 0) b = 8'sd3;
            if (a == -8'sd128 && b == -8'sd1) a = 8'sd9;
            op(a, b, r[9:0], lim);
        end
    endtask
    task automatic idle(input integer c);
        repeat (c) begin
            @(negedge ref_clk_in);
            {dvd_valid_in, dvs_valid_in} = 2'b00;
        end
    endtask
    task automatic drain;
        for (i = 0; i < 800 && exp_q.size() > 0; i++) @(negedge ref_clk_in);
        guard(exp_q.size() == 0, "drain");
    endtask
    task automatic lat(input integer gap, input integer want);
        integer c;
        begin
            op(8'sd100, 8'sd7, 10'h0A2, 200);
            idle(1);
            for (c = 0; c < 200 && dout_valid_out !== 1'b1; c++) begin
                aclken_in = (c < 2 || c >= 2 + gap);
                @(negedge ref_clk_in);
            end
            aclken_in = 1'b1;
            chk("latency", want, c);
            drain;
        end
    endtask
    always @(posedge ref_clk_in) begin
        if (arst_n_in && dout_valid_out === 1'b1 && dout_ready_in === 1'b1) begin
            if (exp_q.size() == 0) chk("extra result", 0, 1);
            else begin
                e = exp_q.pop_front();
                chk("quotient", e[24:17], dout_quot_out);
                chk("remainder", e[16:9], dout_rem_out);
                chk("users", e[8:1], {dout_dvd_user_out, dout_dvs_user_out});
                chk("last", e[0], dout_last_out);
            end
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {failures, compares, acc} = 0;
        seed = 14;
        {dvd_valid_in, dvs_valid_in, dvd_data_in, dvs_data_in} = '0;
        {dvd_user_in, dvs_user_in, dvd_last_in, dvs_last_in} = '0;
        {aclken_in, sclr_n_in, arst_n_in, mode} = 5'h18;
        repeat (2) @(negedge ref_clk_in);
        arst_n_in = 1'b1;
        for (int t = 0; t < 6; t++) begin
            op(tbl[t][15:8], tbl[t][7:0], t[9:0] * 10'h05B, 200);
            guard(ok, "ready");
        end
        mode = 2'h1;
        repeat (30) begin
            rnd_op(200);
            guard(ok, "ready");
        end
        idle(1);
        drain;
        // Dividend alone must not start anything
        @(negedge ref_clk_in);
        dvd_valid_in = 1'b1;
        idle(30);
        mode = 2'h0;
        lat(0, LAT);
        lat(5, LAT + 5);
        mode = 2'h2;
        ok = 1'b1;
        while (ok && acc < 60) begin
            rnd_op(30);
            acc = acc + ok;
        end
        chk("fill refused", 1, acc >= 16 && acc < 60);
        mode = 2'h1;
        drain;
        mode = 2'h2;
        repeat (3) rnd_op(200);
        idle(20);
        sclr_n_in = 1'b0;
        idle(2);
        sclr_n_in = 1'b1;
        exp_q.delete();
        idle(2);
        chk("valid after clear", 0, dout_valid_out);
        mode = 2'h0;
        repeat (4) rnd_op(200);
        idle(1);
        drain;
        end_sim;
    end
endmodule
`default_nettype wire

// File: result_sink.sv
// Downstream consumer of the result channel.
// Assumes the bench selects prompt, random or stalled acceptance.
`timescale 1ns/1ps
`default_nettype none
module result_sink (
    input  wire logic       ref_clk_in,
    input  wire logic [1:0] mode_in,
    output var  logic       dout_ready_out
);
    integer seed;
    integer r;
    initial begin
        seed = 14;
        dout_ready_out = 1'b0;
    end
    // Changes only on the falling edge, away from sampling
    always @(negedge ref_clk_in) begin
        r = $random(seed);
        case (mode_in)
            2'h0: dout_ready_out <= 1'b1;
            2'h1: dout_ready_out <= r[0];
            default: dout_ready_out <= 1'b0;
        endcase
    end
endmodule
`default_nettype wire
